/* snpp_cache.sv */
// Page cache register with per-byte loaded marks
`timescale 1ns/10ps
`default_nettype none
module snpp_cache #(
  parameter int DEPTH = snpp_pkg::PAGE_RAW,
  parameter int AW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear_marks,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_idx,
  output logic [7:0] rd_data,
  output logic rd_loaded
);
  if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_chk
    $error("snpp_cache: DEPTH does not fit AW");
  end

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [DEPTH-1:0] loaded;
    logic [7:0] rd_data;
    logic rd_loaded;
  } snpp_cache_t;

  snpp_cache_t st;
  snpp_cache_t next_st;

  always_comb begin
    next_st = st;
    // Contents survive everything but the presetn reset; clear_marks clears only the marks
    if (clear_marks) begin
      next_st.loaded = '0;
    end
    if (wr_en && int'(wr_idx) < DEPTH) begin
      next_st.mem[wr_idx] = wr_data;
      next_st.loaded[wr_idx] = 1'b1;
    end
    if (int'(rd_idx) < DEPTH) begin
      next_st.rd_data = st.mem[rd_idx];
      next_st.rd_loaded = st.loaded[rd_idx];
    end else begin
      next_st.rd_data = 8'h00;
      next_st.rd_loaded = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign rd_loaded = st.rd_loaded;
endmodule
`default_nettype wire

/* snpp_host_model.sv */
// Host serial-link driver
`timescale 1ns/10ps
`default_nettype none
module snpp_host_model (
  output logic link_cs_n,
  output logic link_sclk,
  output logic [3:0] serial_io_in
);
  initial begin
    link_cs_n = 1;
    link_sclk = 0;
    serial_io_in = 4'hf;
  end
  // Clock stands low between frames; lanes 1-3 held high as if pulled up
  task frame(input logic [7:0] b [4], input int n);
    link_cs_n = 0;
    for (int i = 0; i < n * 8; i++) begin
      serial_io_in[0] = b[i / 8][7 - i % 8];
      #160 link_sclk = 1;
      #160 link_sclk = 0;
    end
    #160 link_cs_n = 1;
    serial_io_in[0] = ~serial_io_in[0];
    #640;
  endtask
endmodule
`default_nettype wire

/* snpp_pkg.sv */
// Shared constants and types of the serial NAND page-program block
package snpp_pkg;
  // Opcodes seen on the serial link
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_LOAD = 8'h02;
  localparam logic [7:0] OP_LOAD_X4 = 8'h32;
  localparam logic [7:0] OP_RAND = 8'h84;
  localparam logic [7:0] OP_RAND_X4A = 8'hc4;
  localparam logic [7:0] OP_RAND_X4B = 8'h34;
  localparam logic [7:0] OP_COMMIT = 8'h10;
  localparam logic [7:0] OP_READ_CACHE = 8'h13;
  localparam logic [7:0] OP_GET_FEAT = 8'h0f;
  localparam logic [7:0] OP_SET_FEAT = 8'h1f;
  localparam logic [7:0] OP_SOFT_RST = 8'hff;
  // Feature addresses and bit positions
  localparam logic [7:0] FEAT_CFG = 8'hb0;
  localparam logic [7:0] FEAT_STAT = 8'hc0;
  localparam int CFG_QE_BIT = 0;
  localparam int CFG_ECC_BIT = 4;
  localparam int STAT_OIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  // Frame layout in link clock edges
  localparam logic [4:0] OPC_BITS = 5'd8;
  localparam logic [4:0] COL_BITS = 5'd16;
  localparam logic [4:0] ROW_BITS = 5'd24;
  localparam logic [4:0] BYTE_BITS = 5'd8;
  // Page sizes
  localparam int PAGE_RAW = 2176;
  localparam int PAGE_ECC = 2112;
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  // Program busy time
  localparam int PROG_TIME_US = 600;
  localparam int CLK_MHZ = 25;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  // Register map (byte addresses)
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_ROW = 12'h004;
  localparam logic [11:0] REG_CTRL = 12'h008;
  localparam int STS_OIP = 0;
  localparam int STS_WEL = 1;
  localparam int STS_QE = 2;
  localparam int STS_ECC = 3;
  localparam int STS_FILL = 4;
  localparam int CTRL_EN = 0;
  localparam logic RST_EN = 1'b1;
  localparam logic RST_QE = 1'b0;
  localparam logic RST_ECC = 1'b1;
  typedef enum logic [2:0] {
    SN_OP, SN_ADDR, SN_DATA, SN_FADDR, SN_FDATA, SN_FOUT, SN_IGN
  } snpp_state_t;
endpackage

/* snpp_top.sv */
// Serial NAND page-program sequencer with APB status and control
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Load frame: opcode, four dummy bits, 12-bit column, then data bytes.
// - Cache holds one page; bytes past the page end are dropped.
// - Chip select rising ends every command and data acceptance.
// - Execute is ignored unless write enable latch is set.
// - Random load and soft reset keep cache contents intact.
// - After normal load, unloaded positions commit as all ones.
// - After random load, whole page commits as it stands.
// - Quad loads accepted only while quad enable bit is set.
// - Page is 2176 bytes, or 2112 with internal ECC on.
// - Execute: opcode plus 24-bit row, then busy for program time.
// - Host polls status while busy, loads again only afterwards.
// - Random load updates only addressed bytes, same framing.
// - Feature get and set use a one-byte feature address.
// - Write enable latch is read-only to feature writes.
// - Quad random loads need quad enable, data on four lanes.
module snpp_top #(
  parameter int PROG_CYCLES = snpp_pkg::PROG_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_cs_n,
  input wire logic link_sclk,
  input wire logic [3:0] serial_io_in,
  output logic [3:0] serial_io_out,
  output logic [3:0] serial_io_oe_n,
  output logic commit_valid,
  output logic [23:0] commit_row,
  output logic [11:0] commit_col,
  output logic [7:0] commit_data
);
  localparam int BW = $clog2(PROG_CYCLES + 1);
  if (PROG_CYCLES < snpp_pkg::PAGE_RAW + 4) begin : g_chk
    $error("snpp_top: PROG_CYCLES shorter than a page walk");
  end

  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] ck_s;
    logic [1:0][3:0] io_s;
    logic ck_prev;
    logic en;
    logic qe;
    logic ecc;
    logic write_enable_latch;
    logic operation_in_progress;
    logic fill;
    logic quad;
    logic is_get;
    snpp_pkg::snpp_state_t fsm;
    logic [7:0] op;
    logic [4:0] bits;
    logic [23:0] addr;
    logic [7:0] dbyte;
    logic [11:0] col;
    logic [7:0] fout;
    logic [2:0] obit;
    logic [3:0] sout;
    logic [3:0] oe_n;
    logic c_clr;
    logic c_we;
    logic [11:0] c_idx;
    logic [7:0] c_data;
    logic [BW-1:0] busy;
    logic walk;
    logic [11:0] widx;
    logic wv;
    logic [11:0] widx1;
    logic [23:0] row;
    logic cv;
    logic [11:0] ccol;
    logic [7:0] cdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } snpp_regs_t;

  snpp_regs_t q;
  snpp_regs_t next_q;
  logic ck_rise;
  logic ck_fall;
  logic active;
  logic [11:0] page_len;
  logic [3:0] lanes;
  logic [7:0] op_in;
  logic [7:0] faddr;
  logic [7:0] feat_byte;
  logic [7:0] rd_byte;
  logic rd_loaded;
  logic [31:0] rdata;
  logic unmapped;

  // Link pins are sampled through two flops; edges come from the second
  assign ck_rise = q.ck_s[1] && !q.ck_prev;
  assign ck_fall = !q.ck_s[1] && q.ck_prev;
  assign active = !q.cs_s[1] && q.en;
  assign page_len = q.ecc ? 12'(snpp_pkg::PAGE_ECC)
                          : 12'(snpp_pkg::PAGE_RAW);
  assign lanes = q.io_s[1];
  assign op_in = {q.op[6:0], lanes[0]};
  assign faddr = {q.addr[6:0], lanes[0]};

  // Feature byte shifted out by a get-feature frame
  always_comb begin
    feat_byte = 8'h00;
    if (faddr == snpp_pkg::FEAT_CFG) begin
      feat_byte[snpp_pkg::CFG_QE_BIT] = q.qe;
      feat_byte[snpp_pkg::CFG_ECC_BIT] = q.ecc;
    end else if (faddr == snpp_pkg::FEAT_STAT) begin
      feat_byte[snpp_pkg::STAT_OIP_BIT] = q.operation_in_progress;
      feat_byte[snpp_pkg::STAT_WEL_BIT] = q.write_enable_latch;
    end
  end

  // Register read decode
  always_comb begin
    rdata = 32'h0000_0000;
    unmapped = 1'b0;
    if (paddr == snpp_pkg::REG_STATUS) begin
      rdata[snpp_pkg::STS_OIP] = q.operation_in_progress;
      rdata[snpp_pkg::STS_WEL] = q.write_enable_latch;
      rdata[snpp_pkg::STS_QE] = q.qe;
      rdata[snpp_pkg::STS_ECC] = q.ecc;
      rdata[snpp_pkg::STS_FILL] = q.fill;
    end else if (paddr == snpp_pkg::REG_ROW) begin
      rdata = {8'h00, q.row};
    end else if (paddr == snpp_pkg::REG_CTRL) begin
      rdata[snpp_pkg::CTRL_EN] = q.en;
    end else begin
      unmapped = 1'b1;
    end
  end

  always_comb begin
    next_q = q;
    next_q.cs_s = {q.cs_s[0], link_cs_n};
    next_q.ck_s = {q.ck_s[0], link_sclk};
    next_q.io_s = {q.io_s[0], serial_io_in};
    next_q.ck_prev = q.ck_s[1];
    next_q.c_we = 1'b0;
    next_q.c_clr = 1'b0;

    // APB answers one cycle into the access phase
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;
    if (psel && penable && !q.pready) begin
      next_q.pready = 1'b1;
      next_q.prdata = rdata;
      next_q.pslverr = unmapped;
    end
    if (psel && penable && q.pready && pwrite &&
        paddr == snpp_pkg::REG_CTRL) begin
      next_q.en = pwdata[snpp_pkg::CTRL_EN];
    end

    // Program busy countdown
    if (q.busy != '0) begin
      next_q.busy = q.busy - BW'(1);
      if (q.busy == BW'(1)) begin
        next_q.operation_in_progress = 1'b0;
        next_q.write_enable_latch = 1'b0;
      end
    end

    // Page walk: cache read takes a cycle, so the column is piped along
    next_q.wv = q.walk;
    next_q.widx1 = q.widx;
    if (q.walk) begin
      if (q.widx == page_len - 12'd1) begin
        next_q.walk = 1'b0;
      end else begin
        next_q.widx = q.widx + 12'd1;
      end
    end
    next_q.cv = q.wv;
    next_q.ccol = q.widx1;
    if (q.fill && !rd_loaded) begin
      next_q.cdata = snpp_pkg::BLANK_BYTE;
    end else begin
      next_q.cdata = rd_byte;
    end

    // Serial link
    if (!active) begin
      next_q.fsm = snpp_pkg::SN_OP;
      next_q.bits = 5'd0;
      next_q.oe_n = 4'hf;
    end else if (ck_fall && q.fsm == snpp_pkg::SN_FOUT) begin
      next_q.sout[1] = q.fout[q.obit];
      next_q.oe_n[1] = 1'b0;
      next_q.obit = q.obit - 3'd1;
    end else if (ck_rise) begin
      next_q.bits = q.bits + 5'd1;
      case (q.fsm)
        snpp_pkg::SN_OP: begin
          next_q.op = op_in;
          if (q.bits == snpp_pkg::OPC_BITS - 5'd1) begin
            next_q.bits = 5'd0;
            next_q.fsm = snpp_pkg::SN_IGN;
            if (op_in == snpp_pkg::OP_SOFT_RST) begin
              // Stops the program and clears the write enable latch; cache and quad enable and ECC feature bits are kept
              next_q.operation_in_progress = 1'b0;
              next_q.write_enable_latch = 1'b0;
              next_q.busy = '0;
              next_q.walk = 1'b0;
            end else if (op_in == snpp_pkg::OP_GET_FEAT) begin
              next_q.is_get = 1'b1;
              next_q.fsm = snpp_pkg::SN_FADDR;
            end else if (q.operation_in_progress) begin
              // Only status polls and soft reset are taken while busy
              next_q.fsm = snpp_pkg::SN_IGN;
            end else if (op_in == snpp_pkg::OP_WREN) begin
              next_q.write_enable_latch = 1'b1;
            end else if (op_in == snpp_pkg::OP_WRDI) begin
              next_q.write_enable_latch = 1'b0;
            end else if (op_in == snpp_pkg::OP_SET_FEAT) begin
              next_q.is_get = 1'b0;
              next_q.fsm = snpp_pkg::SN_FADDR;
            end else if (op_in == snpp_pkg::OP_LOAD ||
                (op_in == snpp_pkg::OP_LOAD_X4 && q.qe)) begin
              // Normal load forgets old marks so its gaps commit blank
              next_q.c_clr = 1'b1;
              next_q.fill = 1'b1;
              next_q.quad = op_in == snpp_pkg::OP_LOAD_X4;
              next_q.fsm = snpp_pkg::SN_ADDR;
            end else if (op_in == snpp_pkg::OP_RAND ||
                ((op_in == snpp_pkg::OP_RAND_X4A ||
                  op_in == snpp_pkg::OP_RAND_X4B) && q.qe)) begin
              next_q.fill = 1'b0;
              next_q.quad = op_in != snpp_pkg::OP_RAND;
              next_q.fsm = snpp_pkg::SN_ADDR;
            end else if (op_in == snpp_pkg::OP_COMMIT) begin
              next_q.fsm = snpp_pkg::SN_ADDR;
            end else if (op_in == snpp_pkg::OP_READ_CACHE) begin
              // Array data arrive elsewhere; the cache commits as it stands
              next_q.fill = 1'b0;
              next_q.fsm = snpp_pkg::SN_ADDR;
            end
          end
        end
        snpp_pkg::SN_ADDR: begin
          next_q.addr = {q.addr[22:0], lanes[0]};
          if (q.op == snpp_pkg::OP_COMMIT ||
              q.op == snpp_pkg::OP_READ_CACHE) begin
            if (q.bits == snpp_pkg::ROW_BITS - 5'd1) begin
              next_q.fsm = snpp_pkg::SN_IGN;
              if (q.op == snpp_pkg::OP_COMMIT && q.write_enable_latch) begin
                next_q.row = {q.addr[22:0], lanes[0]};
                next_q.operation_in_progress = 1'b1;
                next_q.busy = BW'(PROG_CYCLES);
                next_q.walk = 1'b1;
                next_q.widx = 12'd0;
              end
            end
          end else if (q.bits == snpp_pkg::COL_BITS - 5'd1) begin
            // The upper four bits are dummies ahead of the column
            next_q.col = {q.addr[10:0], lanes[0]};
            next_q.bits = 5'd0;
            next_q.fsm = snpp_pkg::SN_DATA;
          end
        end
        snpp_pkg::SN_DATA: begin
          if (q.quad) begin
            next_q.dbyte = {q.dbyte[3:0], lanes};
            next_q.bits = q.bits + 5'd4;
          end else begin
            next_q.dbyte = {q.dbyte[6:0], lanes[0]};
          end
          if ((q.quad && q.bits[2]) ||
              (!q.quad && q.bits[2:0] == 3'd7)) begin
            next_q.bits = 5'd0;
            if (q.col < page_len) begin
              next_q.c_we = 1'b1;
              next_q.c_idx = q.col;
              next_q.c_data = next_q.dbyte;
              next_q.col = q.col + 12'd1;
            end
          end
        end
        snpp_pkg::SN_FADDR: begin
          next_q.addr = {q.addr[22:0], lanes[0]};
          if (q.bits == snpp_pkg::BYTE_BITS - 5'd1) begin
            next_q.bits = 5'd0;
            next_q.obit = 3'd7;
            next_q.fout = feat_byte;
            next_q.fsm = q.is_get ? snpp_pkg::SN_FOUT : snpp_pkg::SN_FDATA;
          end
        end
        snpp_pkg::SN_FDATA: begin
          next_q.dbyte = {q.dbyte[6:0], lanes[0]};
          if (q.bits == snpp_pkg::BYTE_BITS - 5'd1) begin
            next_q.fsm = snpp_pkg::SN_IGN;
            // Status byte is read-only, so the latch keeps its value
            if (q.addr[7:0] == snpp_pkg::FEAT_CFG) begin
              next_q.qe = next_q.dbyte[snpp_pkg::CFG_QE_BIT];
              next_q.ecc = next_q.dbyte[snpp_pkg::CFG_ECC_BIT];
            end
          end
        end
        snpp_pkg::SN_FOUT: begin
          next_q.fsm = snpp_pkg::SN_FOUT;
        end
        default: begin
          next_q.fsm = snpp_pkg::SN_IGN;
        end
      endcase
    end
  end

  snpp_cache #(
    .DEPTH(snpp_pkg::PAGE_RAW),
    .AW(12)
  ) u_cache (
    .pclk(pclk),
    .presetn(presetn),
    .clear_marks(q.c_clr),
    .wr_en(q.c_we),
    .wr_idx(q.c_idx),
    .wr_data(q.c_data),
    .rd_idx(q.widx),
    .rd_data(rd_byte),
    .rd_loaded(rd_loaded)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.cs_s <= 2'b11;
      q.en <= snpp_pkg::RST_EN;
      q.qe <= snpp_pkg::RST_QE;
      q.ecc <= snpp_pkg::RST_ECC;
      q.oe_n <= 4'hf;
      q.fsm <= snpp_pkg::SN_OP;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign serial_io_out = q.sout;
  assign serial_io_oe_n = q.oe_n;
  assign commit_valid = q.cv;
  assign commit_row = q.row;
  assign commit_col = q.ccol;
  assign commit_data = q.cdata;
endmodule
`default_nettype wire

/* snpp_top_assertions.sv */
// Port checker for snpp_top
`timescale 1ns/10ps
`default_nettype none
module snpp_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic link_cs_n,
  input wire logic [3:0] serial_io_oe_n,
  input wire logic commit_valid,
  input wire logic [23:0] commit_row,
  input wire logic [11:0] commit_col
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_burst; commit_valid ##1 commit_valid; endsequence
  chk_col_in_page: assert property (commit_valid |-> commit_col < 12'd2176)
    else $error("commit column past page");
  chk_idle_released: assert property (link_cs_n [*4] |-> &serial_io_oe_n)
    else $error("lanes driven while deselected");
  chk_lane0_input: assert property (serial_io_oe_n[0])
    else $error("lane 0 driven");
  chk_quad_released: assert property (&serial_io_oe_n[3:2])
    else $error("quad lanes driven");
  chk_row_held: assert property (s_burst |-> $stable(commit_row))
    else $error("row moved in commit");
  chk_col_step: assert property (s_burst |-> commit_col == $past(commit_col) + 12'h1)
    else $error("commit column skipped");
  chk_first_col: assert property ($rose(commit_valid) |-> commit_col == 12'h0)
    else $error("commit not from column 0");
  chk_ready_bound: assert property (psel && penable |-> ##[0:8] pready)
    else $error("status access hung");
endmodule
bind snpp_top snpp_top_assertions u_chk (.*);
`default_nettype wire

/* snpp_top_tb_top.sv */
// Self-checking bench of snpp_top
`timescale 1ns/10ps
`default_nettype none
module snpp_top_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic pready, pslverr, cs_n, sclk, valid;
  logic [11:0] paddr = 0, col;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] sio, sio_out, oe_n;
  logic [23:0] row;
  logic [7:0] data, pg [4096];
  int fails = 0, comparisons = 0, ncommit = 0;
  initial forever #20 pclk = ~pclk;
  initial begin
    #3000000;
    fails++;
    results;
  end
  snpp_host_model u_host (.link_cs_n(cs_n), .link_sclk(sclk),
    .serial_io_in(sio));
  snpp_top #(.PROG_CYCLES(3000)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_cs_n(cs_n), .link_sclk(sclk), .serial_io_in(sio),
    .serial_io_out(sio_out), .serial_io_oe_n(oe_n), .commit_valid(valid),
    .commit_row(row), .commit_col(col), .commit_data(data));
  always @(posedge pclk) if (valid) begin
    pg[col] <= data;
    ncommit <= ncommit + 1;
  end
  task chk(string n, logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task load(logic [7:0] op, logic [11:0] c, logic [7:0] d);
    u_host.frame('{op, {4'h0, c[11:8]}, c[7:0], d}, 4);
  endtask
  // Optional write enable, execute, then status polls; rows rise per page
  task commit(logic wren, logic [23:0] r);
    if (wren) u_host.frame('{snpp_pkg::OP_WREN, 8'h0, 8'h0, 8'h0}, 1);
    ncommit = 0;
    u_host.frame('{snpp_pkg::OP_COMMIT, r[23:16], r[15:8], r[7:0]}, 4);
    rd = 1;
    while (rd[snpp_pkg::STS_OIP] !== 0) apb(0, snpp_pkg::REG_STATUS, 0);
    chk("wel_clear", rd[snpp_pkg::STS_WEL], 0);
  endtask
  task t_features;
    u_host.frame('{snpp_pkg::OP_LOAD_X4, 8'h0, 8'h0, 8'h0}, 4);
    apb(0, snpp_pkg::REG_STATUS, 0);
    chk("quad_refused", rd[snpp_pkg::STS_FILL], 0);
    u_host.frame('{snpp_pkg::OP_SET_FEAT, snpp_pkg::FEAT_STAT, 8'h02, 8'h0}, 3);
    u_host.frame('{snpp_pkg::OP_SET_FEAT, snpp_pkg::FEAT_CFG, 8'h11, 8'h0}, 3);
    apb(0, snpp_pkg::REG_STATUS, 0);
    chk("wel_ro", rd[snpp_pkg::STS_WEL], 0);
    chk("qe_set", rd[snpp_pkg::STS_QE], 1);
    chk("ecc_on", rd[snpp_pkg::STS_ECC], 1);
    apb(0, 12'hffc, 0);
    chk("unmapped", err, 1);
  endtask
  task t_blank;
    load(snpp_pkg::OP_LOAD, 12'h3, 8'ha5);
    commit(0, 24'h000100);
    chk("no_wren", ncommit, 0);
    commit(1, 24'h000100);
    chk("page_len", ncommit, snpp_pkg::PAGE_ECC);
    chk("loaded", pg[3], 8'ha5);
    chk("blank", pg[4], 8'hff);
    apb(0, snpp_pkg::REG_ROW, 0);
    chk("row", rd, 32'h0000_0100);
  endtask
  task t_move;
    u_host.frame('{snpp_pkg::OP_SOFT_RST, 8'h0, 8'h0, 8'h0}, 1);
    u_host.frame('{snpp_pkg::OP_READ_CACHE, 8'h0, 8'h1, 8'h0}, 4);
    load(snpp_pkg::OP_RAND, 12'h4, 8'h5a);
    commit(1, 24'h000101);
    chk("kept", pg[3], 8'ha5);
    chk("patched", pg[4], 8'h5a);
  endtask
  task results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_features;
    t_blank;
    t_move;
    results;
  end
endmodule
`default_nettype wire
